// ==== rtl/cie_pkg.sv ====
// Package of constants and types for the interrupt entry and return unit
package cie_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_SRC = 8;
    localparam int PC_W = 12;
    localparam int SP_W = 16;

    // ****************************************
    // Register map, byte addresses
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FLAG = 8'h04;
    localparam logic [7:0] OFS_ENABLE = 8'h08;
    localparam logic [7:0] OFS_KIND = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_SP = 8'h14;
    localparam logic [7:0] OFS_BOOT = 8'h18;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int GIE_BIT = 7;
    localparam int CTRL_VEC_SEL_BIT = 0;
    localparam int CTRL_RST_VEC_FUSE_BIT = 1;
    localparam int CTRL_APPLOCK_BIT = 2;
    localparam int CTRL_BOOTLOCK_BIT = 3;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [15:0] SP_RST = 16'h0000;
    localparam logic [11:0] BOOT_START_RST = 12'h0C00;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ****************************************
    // Timing counts, core clock cycles
    // ****************************************
    localparam logic [2:0] ENTRY_CYC = 3'd4;
    localparam logic [2:0] WAKE_EXTRA_CYC = 3'd4;
    localparam logic [2:0] RETURN_CYC = 3'd4;
    localparam logic [2:0] JUMP_CYC = 3'd3;
    localparam logic [11:0] VEC_STEP = 12'h001;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        ST_RUN, ST_WAKE, ST_ENTRY, ST_JUMP, ST_RETURN
    } cie_state_t;

    typedef struct packed {
        logic exec_done;
        logic multi_busy;
        logic is_irq_return;
        logic is_sei;
        logic is_gie_clear;
        logic sleeping;
        logic [11:0] jump_target;
        logic [15:0] pop_pc;
    } cie_core_in_t;

    typedef struct packed {
        logic ack;
        logic [2:0] idx;
        logic [11:0] vec;
    } cie_take_t;

    typedef struct packed {
        cie_state_t st;
        logic [2:0] cnt;
        logic one_more;
        logic [7:0] status;
        logic [15:0] sp;
        logic [7:0] flags;
        logic [7:0] enables;
        logic [7:0] kind;
        logic [3:0] ctrl;
        logic [11:0] boot_start;
        logic [11:0] pc;
        logic push_en;
        logic [15:0] push_data;
        logic stall;
        cie_take_t take;
        logic awdone;
        logic wdone;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } cie_state_s_t;
endpackage : cie_pkg

// ==== rtl/cie_unit.sv ====
// Interrupt entry, vectoring and return sequencer with AXI4-Lite registers
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
// ****************************************
// ****************************************
module cie_unit #(
    parameter int NSRC = cie_pkg::NUM_SRC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Peripheral sources: flag events and level conditions
    input wire logic [NSRC-1:0] irq_event,
    input wire logic [NSRC-1:0] irq_level,
    // Core side
    input wire cie_pkg::cie_core_in_t core_in,
    output logic [11:0] core_pc,
    output logic core_stall,
    output logic push_en,
    output logic [15:0] push_data,
    output logic [15:0] core_sp,
    output logic [7:0] core_status_register,
    output cie_pkg::cie_take_t take
);
    cie_pkg::cie_state_s_t q, d;

    // ****************************************
    // Request arbitration
    // ****************************************
    logic [7:0] req;
    logic allow;
    logic [2:0] win;
    logic any;
    logic pc_in_locked;

    // Lock suppression: app lock guards below boot, boot lock guards boot section
    always_comb begin
        pc_in_locked = (q.ctrl[cie_pkg::CTRL_APPLOCK_BIT] && q.pc < q.boot_start)
            || (q.ctrl[cie_pkg::CTRL_BOOTLOCK_BIT] && q.pc >= q.boot_start);
    end

    // Flags pend until taken or cleared; level sources only while asserted
    always_comb begin
        req = ((q.flags & ~q.kind) | (8'(irq_level) & q.kind)) & q.enables;
        allow = q.status[cie_pkg::GIE_BIT] && !core_in.is_gie_clear && !q.one_more
            && !pc_in_locked && !core_in.multi_busy && core_in.exec_done;
        win = 3'd0;
        any = |req;
        // Lowest index wins, searching downward so the last hit is lowest
        for (int i = 7; i >= 0; i--) begin
            if (req[i]) begin
                win = 3'(i);
            end
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    logic aw_take, w_take, ar_take;
    logic [7:0] wb;
    logic [7:0] vec_base;

    always_comb begin
        d = q;
        wb = 8'h00;
        vec_base = 8'h00;
        d.push_en = 1'b0;
        d.take.ack = 1'b0;
        aw_take = s_axi_awvalid && !q.awdone && !q.bvalid;
        w_take = s_axi_wvalid && !q.wdone && !q.bvalid;
        ar_take = s_axi_arvalid && !q.rvalid;
        // Vector table base: low byte of boot start when relocated
        vec_base = q.ctrl[cie_pkg::CTRL_VEC_SEL_BIT] ? q.boot_start[7:0] : 8'h00;

        // Global enable from set and clear instructions; clear wins over set
        if (core_in.is_sei) begin
            d.status[cie_pkg::GIE_BIT] = 1'b1;
            d.one_more = 1'b1;
        end
        if (core_in.is_gie_clear) begin
            d.status[cie_pkg::GIE_BIT] = 1'b0;
        end
        if (core_in.exec_done && q.st == cie_pkg::ST_RUN && !core_in.is_sei) begin
            d.one_more = 1'b0;
        end

        unique case (q.st)
            cie_pkg::ST_RUN: begin
                d.stall = 1'b0;
                d.pc = core_in.jump_target;
                if (core_in.is_irq_return) begin
                    d.st = cie_pkg::ST_RETURN;
                    d.cnt = cie_pkg::RETURN_CYC - 3'd1;
                    d.stall = 1'b1;
                end else if (allow && any) begin
                    d.stall = 1'b1;
                    d.take.idx = win;
                    d.take.vec = q.boot_start & {12{q.ctrl[cie_pkg::CTRL_VEC_SEL_BIT]}};
                    d.take.vec = d.take.vec + (12'(win) + cie_pkg::VEC_STEP);
                    d.status[cie_pkg::GIE_BIT] = 1'b0;
                    if (!q.kind[win]) begin
                        d.flags[win] = 1'b0;
                    end
                    if (core_in.sleeping) begin
                        d.st = cie_pkg::ST_WAKE;
                        d.cnt = cie_pkg::WAKE_EXTRA_CYC - 3'd1;
                    end else begin
                        d.st = cie_pkg::ST_ENTRY;
                        d.cnt = cie_pkg::ENTRY_CYC - 3'd1;
                    end
                end
            end
            cie_pkg::ST_WAKE: begin
                d.cnt = q.cnt - 3'd1;
                if (q.cnt == 3'd0) begin
                    d.st = cie_pkg::ST_ENTRY;
                    d.cnt = cie_pkg::ENTRY_CYC - 3'd1;
                end
            end
            cie_pkg::ST_ENTRY: begin
                d.cnt = q.cnt - 3'd1;
                if (q.cnt == cie_pkg::ENTRY_CYC - 3'd1) begin
                    d.push_en = 1'b1;
                    d.push_data = {4'h0, q.pc};
                    d.sp = q.sp - 16'd2;
                end
                if (q.cnt == 3'd0) begin
                    d.pc = q.take.vec;
                    d.take.ack = 1'b1;
                    d.st = cie_pkg::ST_JUMP;
                    d.cnt = cie_pkg::JUMP_CYC - 3'd1;
                end
            end
            cie_pkg::ST_JUMP: begin
                d.cnt = q.cnt - 3'd1;
                if (q.cnt == 3'd0) begin
                    d.pc = core_in.jump_target;
                    d.st = cie_pkg::ST_RUN;
                    d.stall = 1'b0;
                end
            end
            cie_pkg::ST_RETURN: begin
                d.cnt = q.cnt - 3'd1;
                if (q.cnt == 3'd0) begin
                    d.pc = core_in.pop_pc[11:0];
                    d.sp = q.sp + 16'd2;
                    d.status[cie_pkg::GIE_BIT] = 1'b1;
                    d.one_more = 1'b1;
                    d.st = cie_pkg::ST_RUN;
                    d.stall = 1'b0;
                end
            end
        endcase

        // Write channel capture, either order
        if (aw_take) begin
            d.awdone = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (w_take) begin
            d.wdone = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (q.awdone && q.wdone && !q.bvalid) begin
            wb = q.wstrb[0] ? q.wdata[7:0] : 8'h00;
            d.awdone = 1'b0;
            d.wdone = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = cie_pkg::RESP_OKAY;
            unique case ({q.awaddr[7:2], 2'b00})
                cie_pkg::OFS_CTRL: if (q.wstrb[0]) d.ctrl = wb[3:0];
                cie_pkg::OFS_FLAG: d.flags = q.flags & ~wb;
                cie_pkg::OFS_ENABLE: if (q.wstrb[0]) d.enables = wb;
                cie_pkg::OFS_KIND: if (q.wstrb[0]) d.kind = wb;
                cie_pkg::OFS_STATUS: if (q.wstrb[0]) d.status = wb;
                cie_pkg::OFS_SP: begin
                    if (q.wstrb[0]) d.sp[7:0] = q.wdata[7:0];
                    if (q.wstrb[1]) d.sp[15:8] = q.wdata[15:8];
                end
                cie_pkg::OFS_BOOT: begin
                    if (q.wstrb[0]) d.boot_start[7:0] = q.wdata[7:0];
                    if (q.wstrb[1]) d.boot_start[11:8] = q.wdata[11:8];
                end
                default: d.bresp = cie_pkg::RESP_SLVERR;
            endcase
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end

        // Event flags set after software clear so the set wins
        d.flags = d.flags | (8'(irq_event) & ~q.kind);

        // Read channel
        if (ar_take) begin
            d.rvalid = 1'b1;
            d.rresp = cie_pkg::RESP_OKAY;
            unique case ({s_axi_araddr[7:2], 2'b00})
                cie_pkg::OFS_CTRL: d.rdata = {28'h000_0000, q.ctrl};
                cie_pkg::OFS_FLAG: d.rdata = {24'h00_0000, q.flags};
                cie_pkg::OFS_ENABLE: d.rdata = {24'h00_0000, q.enables};
                cie_pkg::OFS_KIND: d.rdata = {24'h00_0000, q.kind};
                cie_pkg::OFS_STATUS: d.rdata = {24'h00_0000, q.status};
                cie_pkg::OFS_SP: d.rdata = {16'h0000, q.sp};
                cie_pkg::OFS_BOOT: d.rdata = {20'h0_0000, q.boot_start};
                default: begin
                    d.rdata = 32'h0000_0000;
                    d.rresp = cie_pkg::RESP_SLVERR;
                end
            endcase
        end else if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end

        // Read data held when the vector base is FF; the reset pc stays 000
        if (vec_base == 8'hFF) begin
            d.rdata = q.rdata;
        end
    end

    // ****************************************
    // State register, single undivided clock
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.st <= cie_pkg::ST_RUN;
            q.status <= cie_pkg::STATUS_RST;
            q.sp <= cie_pkg::SP_RST;
            q.boot_start <= cie_pkg::BOOT_START_RST;
            q.pc <= 12'h000;
        end else begin
            q <= d;
        end
    end

    // Outputs from flip-flops; the ready outputs are gates of them
    assign s_axi_awready = !q.awdone && !q.bvalid;
    assign s_axi_wready = !q.wdone && !q.bvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign core_pc = q.pc;
    assign core_stall = q.stall;
    assign push_en = q.push_en;
    assign push_data = q.push_data;
    assign core_sp = q.sp;
    assign core_status_register = q.status;
    assign take = q.take;

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_entry;
        q.st == cie_pkg::ST_ENTRY [*4];
    endsequence

    property p_entry_len;
        @(posedge aclk) disable iff (!aresetn)
        ($rose(q.st == cie_pkg::ST_ENTRY)) |-> s_entry ##1 (q.st == cie_pkg::ST_JUMP);
    endproperty
    a_entry_len: assert property (p_entry_len) else $error("entry not four cycles");

    property p_gie_clear;
        @(posedge aclk) disable iff (!aresetn)
        ($rose(q.st == cie_pkg::ST_ENTRY) && $past(q.st) == cie_pkg::ST_RUN)
            |-> !q.status[cie_pkg::GIE_BIT];
    endproperty
    a_gie_clear: assert property (p_gie_clear) else $error("global enable kept on entry");

    property p_cli_block;
        @(posedge aclk) disable iff (!aresetn)
        core_in.is_gie_clear && q.st == cie_pkg::ST_RUN |=> q.st != cie_pkg::ST_ENTRY;
    endproperty
    a_cli_block: assert property (p_cli_block) else $error("entry after clear");

    property p_ret;
        @(posedge aclk) disable iff (!aresetn)
        (q.st == cie_pkg::ST_RUN && core_in.is_irq_return)
            |=> (q.st == cie_pkg::ST_RETURN) [*4] ##1 (q.status[cie_pkg::GIE_BIT] && q.one_more);
    endproperty
    a_ret: assert property (p_ret) else $error("return not four cycles");

    property p_push_sp;
        @(posedge aclk) disable iff (!aresetn)
        q.push_en |-> q.sp == $past(q.sp) - 16'd2;
    endproperty
    a_push_sp: assert property (p_push_sp) else $error("push not minus two");

    property p_one_more;
        @(posedge aclk) disable iff (!aresetn)
        q.one_more && q.st == cie_pkg::ST_RUN |=> q.st != cie_pkg::ST_ENTRY;
    endproperty
    a_one_more: assert property (p_one_more) else $error("no instruction between");

    property p_jump;
        @(posedge aclk) disable iff (!aresetn)
        $rose(q.st == cie_pkg::ST_JUMP) |-> ##3 q.st == cie_pkg::ST_RUN;
    endproperty
    a_jump: assert property (p_jump) else $error("jump not three cycles");

    property p_flag_clr;
        @(posedge aclk) disable iff (!aresetn)
        $rose(q.st == cie_pkg::ST_ENTRY) && $past(q.st) == cie_pkg::ST_RUN
            && !q.kind[q.take.idx] && !$past(irq_event[q.take.idx])
            |-> !q.flags[q.take.idx];
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

    property p_wake;
        @(posedge aclk) disable iff (!aresetn)
        $rose(q.st == cie_pkg::ST_WAKE) |-> (q.st == cie_pkg::ST_WAKE) [*4] ##1 s_entry;
    endproperty
    a_wake: assert property (p_wake) else $error("wake not four extra");
endmodule : cie_unit

// ==== test/cie_core_model.sv ====
// Behavioural model of the execution core that faces the interrupt unit
`timescale 1ns/10ps
module cie_core_model #(
    parameter logic [15:0] RET_PC = 16'h0123
) (
    // Reset
    input wire logic aresetn,
    // Instruction request from the bench
    input wire logic op_req,
    input wire logic [2:0] op,
    // From the unit
    input wire logic core_stall,
    output cie_pkg::cie_core_in_t core_in
);
    // One single-cycle instruction retires on every unstalled cycle
    // Stack contents are not modelled: every return pops the same address
    always_comb begin
        core_in = '0;
        core_in.exec_done = aresetn && !core_stall;
        core_in.is_irq_return = op_req && !core_stall && op[2];
        core_in.is_sei = op_req && !core_stall && op[1];
        core_in.is_gie_clear = op_req && !core_stall && op[0];
        core_in.jump_target = 12'h100;
        core_in.pop_pc = RET_PC;
    end
endmodule : cie_core_model

// ==== test/test_cpu_interrupt_entry_return.sv ====
// Self-checking bench for the interrupt entry and return unit
`timescale 1ns/10ps
module test_cpu_interrupt_entry_return;
    // ****************************************
    // Signals
    // ****************************************
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, op_req;
    logic awready, wready, bvalid, arready, rvalid, core_stall, push_en;
    logic [7:0] awaddr, araddr, irq_event, irq_level, status;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [2:0] op;
    logic [1:0] bresp, rresp;
    logic [11:0] core_pc;
    logic [15:0] push_data, core_sp;
    cie_pkg::cie_core_in_t core_in;
    cie_pkg::cie_take_t take;
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;

    cie_unit dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_event(irq_event),
        .irq_level(irq_level), .core_in(core_in), .core_pc(core_pc),
        .core_stall(core_stall), .push_en(push_en), .push_data(push_data),
        .core_sp(core_sp), .core_status_register(status), .take(take));

    cie_core_model core_u (.aresetn(aresetn), .op_req(op_req), .op(op),
        .core_stall(core_stall), .core_in(core_in));

    // Free-running 200 MHz clock
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            test_done();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready && awvalid) awvalid <= 1'b0;
            if (wready && wvalid) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready && arvalid) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        check("rdata", d, exp);
        check("rresp", 32'(r), 32'(cie_pkg::RESP_OKAY));
    endtask : rchk

    // One instruction (op bits: return, set, clear) with a source pulse beside it
    task automatic issue(input logic [2:0] o, input logic [7:0] ev);
        op <= o;
        op_req <= 1'b1;
        irq_event <= ev;
        @(posedge aclk);
        irq_event <= 8'h00;
        while (core_stall === 1'b1) @(posedge aclk);
        op_req <= 1'b0;
    endtask : issue

    // Watch a fixed window for the vector being reached
    task automatic take_chk(input logic got, input logic [2:0] idx, input logic [11:0] vec);
        logic seen;
        seen = 1'b0;
        repeat (20) begin
            @(posedge aclk);
            if (take.ack === 1'b1 && !seen) begin
                seen = 1'b1;
                check("take.idx", 32'(take.idx), 32'(idx));
                check("take.vec", 32'(take.vec), 32'(vec));
            end
        end
        check("take.ack", 32'(seen), 32'(got));
    endtask : take_chk

    task automatic ret_chk(input logic [7:0] st);
        int n;
        issue(3'b100, 8'h00);
        n = 0;
        while (status[7] !== 1'b1 && n < 10) begin
            @(posedge aclk);
            n++;
        end
        check("status", 32'(status), 32'(st));
        check("sp", 32'(core_sp), 32'h0000_0400);
        check("pc", 32'(core_pc), 32'h0000_0123);
    endtask : ret_chk

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        {awvalid, wvalid, bready, arvalid, rready, op_req} = '0;
        {awaddr, araddr, wdata, wstrb, op, irq_event, irq_level} = '0;
        aresetn = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rchk(cie_pkg::OFS_STATUS, 32'(cie_pkg::STATUS_RST));
        rchk(cie_pkg::OFS_BOOT, 32'(cie_pkg::BOOT_START_RST));
        rd(8'h40, d, r);
        check("unmapped", {d[29:0], r}, 32'(cie_pkg::RESP_SLVERR));
        // Flag pending while global enable is off, served after set
        wr(cie_pkg::OFS_SP, 32'h0000_0400);
        wr(cie_pkg::OFS_ENABLE, 32'h0000_0008);
        issue(3'b000, 8'h08);
        take_chk(1'b0, 3'd0, 12'h000);
        rchk(cie_pkg::OFS_FLAG, 32'h0000_0008);
        issue(3'b010, 8'h00);
        take_chk(1'b1, 3'd3, 12'h004);
        check("gie", 32'(status), 32'h0000_0000);
        check("sp", 32'(core_sp), 32'h0000_03FE);
        rchk(cie_pkg::OFS_FLAG, 32'h0000_0000);
        ret_chk(8'h80);
        // Two sources at once: lower vector first, the other after return
        wr(cie_pkg::OFS_ENABLE, 32'h0000_0024);
        issue(3'b000, 8'h24);
        take_chk(1'b1, 3'd2, 12'h003);
        ret_chk(8'h80);
        take_chk(1'b1, 3'd5, 12'h006);
        ret_chk(8'h80);
        // Write one clears only that flag
        issue(3'b001, 8'h03);
        wr(cie_pkg::OFS_FLAG, 32'h0000_0001);
        rchk(cie_pkg::OFS_FLAG, 32'h0000_0002);
        wr(cie_pkg::OFS_FLAG, 32'h0000_0002);
        rchk(cie_pkg::OFS_FLAG, 32'h0000_0000);
        // Set instruction turns the global enable back on
        issue(3'b010, 8'h00);
        // A live level request meets the clear instruction in its own cycle
        wr(cie_pkg::OFS_KIND, 32'h0000_0010);
        wr(cie_pkg::OFS_ENABLE, 32'h0000_0011);
        irq_level <= 8'h10;
        issue(3'b001, 8'h01);
        irq_level <= 8'h00;
        take_chk(1'b0, 3'd0, 12'h000);
        rchk(cie_pkg::OFS_FLAG, 32'h0000_0001);
        wr(cie_pkg::OFS_FLAG, 32'h0000_0001);
        // Level source gone before enabling, then held
        wr(cie_pkg::OFS_KIND, 32'h0000_0040);
        wr(cie_pkg::OFS_ENABLE, 32'h0000_0040);
        irq_level <= 8'h40;
        repeat (3) @(posedge aclk);
        irq_level <= 8'h00;
        issue(3'b010, 8'h00);
        take_chk(1'b0, 3'd0, 12'h000);
        irq_level <= 8'h40;
        take_chk(1'b1, 3'd6, 12'h007);
        irq_level <= 8'h00;
        ret_chk(8'h80);
        // Vectors moved to the boot start; other status bits untouched
        wr(cie_pkg::OFS_CTRL, 32'h0000_0001);
        wr(cie_pkg::OFS_ENABLE, 32'h0000_0002);
        wr(cie_pkg::OFS_STATUS, 32'h0000_0085);
        issue(3'b000, 8'h02);
        take_chk(1'b1, 3'd1, cie_pkg::BOOT_START_RST + 12'h002);
        check("status", 32'(status), 32'h0000_0005);
        ret_chk(8'h85);
        // App lock with the counter below boot start holds the request back
        wr(cie_pkg::OFS_CTRL, 32'h0000_0004);
        issue(3'b000, 8'h02);
        take_chk(1'b0, 3'd0, 12'h000);
        wr(cie_pkg::OFS_CTRL, 32'h0000_0000);
        take_chk(1'b1, 3'd1, 12'h002);
        test_done();
    end
endmodule : test_cpu_interrupt_entry_return
